// File: rtl/pfcc_params.svh
// Constants for the per-function command register bank.
`ifndef PFCC_PARAMS_SVH
`define PFCC_PARAMS_SVH
`define PFCC_CMD_OFFSET    8'h04
`define PFCC_NUM_FUNC      3
`define PFCC_BIT_IO        0
`define PFCC_BIT_MEM       1
`define PFCC_BIT_MASTER    2
`define PFCC_BIT_SPECIAL   3
`define PFCC_BIT_MWI       4
`define PFCC_BIT_PALETTE   5
`define PFCC_BIT_PARITY    6
`define PFCC_BIT_STEP      7
`define PFCC_BIT_SERR      8
`define PFCC_BIT_FBB       9
`define PFCC_WRITE_MASK    16'h0167
`define PFCC_RESET_VALUE   16'h0000
`define PFCC_ZERO_FUNC     2'h0
`endif

// File: rtl/pfcc_pkg.sv
// Types shared by the command register bank.
package pfcc_pkg;
   typedef logic [1:0]  pfcc_func_t;
   typedef logic [15:0] pfcc_word_t;
   // One configuration access as seen by the bank.
   typedef struct packed {
      logic       cfgWrite;
      pfcc_func_t func;
      logic [7:0] offset;
      logic [1:0] byteEn;
      pfcc_word_t wrData;
   } pfcc_cfg_s;
   // Decoded per-function enables driven into the function logic.
   typedef struct packed {
      logic ioSpaceEnable;
      logic memSpaceEnable;
      logic bus_initiator_enable;
      logic paletteSnoop;
      logic parity_response_enable;
      logic sys_error_driver_enable;
   } pfcc_ctrl_s;
endpackage

// File: rtl/pfcc_cmd_reg.sv
// One function's command register with its fixed-zero bits.
`include "pfcc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pfcc_cmd_reg (
   // Clock and reset.
   input  wire logic               clock,
   input  wire logic               rst_n,
   // Write request for this function.
   input  wire logic               wrStrobe,
   input  wire logic [1:0]         byteEn,
   input  wire pfcc_pkg::pfcc_word_t wrData,
   // Stored register value.
   output var  pfcc_pkg::pfcc_word_t value
);
   typedef struct packed {
      pfcc_pkg::pfcc_word_t cmd;
   } pfcc_reg_state_s;
   pfcc_reg_state_s state_q;
   pfcc_reg_state_s state_d;
   logic [15:0]     laneMask;

   // Lane mask combines byte enables with the writable-bit mask.
   assign laneMask = {{8{byteEn[1]}}, {8{byteEn[0]}}} & `PFCC_WRITE_MASK;

   // Merge new bits; read-only bits never pick up written data.
   always_comb begin
      state_d = state_q;
      if (wrStrobe) begin
         state_d.cmd = (state_q.cmd & ~laneMask) | (wrData & laneMask);
      end
      state_d.cmd = state_d.cmd & `PFCC_WRITE_MASK;
   end

   // Register the state; reset clears all writable bits.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q.cmd <= `PFCC_RESET_VALUE;
      end else begin
         state_q <= state_d;
      end
   end

   assign value = state_q.cmd;
endmodule
`default_nettype wire

// File: rtl/pfcc_command_bank.sv
// Command register bank for the three functions with derived enables.
//
// How it works
// - Separate command register per function.
// - Error enables ORed across all functions.
// - Bits 15 to 10 read zero.
// - Fast back-to-back bit reads zero.
// - Bit 8 enables system error driver.
// - Address parity reported when 8 and 6 set.
// - Bit 6 gates parity error response.
// - Stepping bit hardwired zero.
// - Bit 5 snoops palette writes unclaimed.
// - Write-invalidate bit zero; plain writes only.
// - Special cycles never answered.
// - Bus requests only while bit 2 set.
// - Memory space claimed only with bit 1.
// - I/O space claimed only with bit 0.
`include "pfcc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pfcc_command_bank (
   // Clock and reset.
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // Configuration access.
   input  wire pfcc_pkg::pfcc_cfg_s   cfg,
   output var   pfcc_pkg::pfcc_word_t rdData,
   // Per-function decode requests from the bus target logic.
   input  wire logic [2:0]            memHit,
   input  wire logic [2:0]            ioHit,
   input  wire logic [2:0]            paletteWrite,
   input  wire logic [2:0]            specialCycle,
   input  wire logic [2:0]            masterWant,
   // Parity error detection.
   input  wire logic                  addrParityErr,
   input  wire logic                  dataParityErr,
   // Per-function enables.
   output var   pfcc_pkg::pfcc_ctrl_s [2:0] ctrl,
   // Claims and initiator grants.
   output logic [2:0]                 memClaim,
   output logic [2:0]                 ioClaim,
   output logic [2:0]                 paletteSnoopCapture,
   output logic [2:0]                 specialClaim,
   output logic [2:0]                 busRequest,
   output logic [2:0]                 writeInvalidateUse,
   // Error signalling, registered.
   output logic                       serrAssert,
   output logic                       perrAssert
);
   typedef struct packed {
      logic serr;
      logic perr;
   } pfcc_bank_state_s;
   pfcc_bank_state_s              state_q;
   pfcc_bank_state_s              state_d;
   pfcc_pkg::pfcc_word_t [2:0]    cmdValue;
   logic                          cmdHit;
   logic                          anySerrEn;
   logic                          anyParityEn;

   assign cmdHit = cfg.offset == `PFCC_CMD_OFFSET;

   // One register per function with its own write strobe.
   generate
      for (genvar f = 0; f < `PFCC_NUM_FUNC; f++) begin : g_func
         pfcc_cmd_reg u_reg (
            .clock    (clock),
            .rst_n    (rst_n),
            .wrStrobe (cfg.cfgWrite && cmdHit && (cfg.func == 2'(f))),
            .byteEn   (cfg.byteEn),
            .wrData   (cfg.wrData),
            .value    (cmdValue[f])
         );
         // Decode enables and gate claims per function.
         assign ctrl[f].ioSpaceEnable           = cmdValue[f][`PFCC_BIT_IO];
         assign ctrl[f].memSpaceEnable          = cmdValue[f][`PFCC_BIT_MEM];
         assign ctrl[f].bus_initiator_enable    = cmdValue[f][`PFCC_BIT_MASTER];
         assign ctrl[f].paletteSnoop            = cmdValue[f][`PFCC_BIT_PALETTE];
         assign ctrl[f].parity_response_enable  = cmdValue[f][`PFCC_BIT_PARITY];
         assign ctrl[f].sys_error_driver_enable = cmdValue[f][`PFCC_BIT_SERR];
         assign memClaim[f] = memHit[f] && cmdValue[f][`PFCC_BIT_MEM] &&
                              !(paletteWrite[f] && cmdValue[f][`PFCC_BIT_PALETTE]);
         assign ioClaim[f]  = ioHit[f] && cmdValue[f][`PFCC_BIT_IO] &&
                              !(paletteWrite[f] && cmdValue[f][`PFCC_BIT_PALETTE]);
         assign paletteSnoopCapture[f] = paletteWrite[f] && cmdValue[f][`PFCC_BIT_PALETTE];
         assign specialClaim[f]       = specialCycle[f] & 1'b0;
         assign writeInvalidateUse[f] = cmdValue[f][`PFCC_BIT_MWI];
         assign busRequest[f] = masterWant[f] && cmdValue[f][`PFCC_BIT_MASTER];
      end
   endgenerate

   // Read data: selected function's value, bits 15..9, 7, 4, 3 are zero.
   always_comb begin
      rdData = 16'h0000;
      if (cmdHit && cfg.func < 2'(`PFCC_NUM_FUNC)) begin
         rdData = cmdValue[cfg.func] & `PFCC_WRITE_MASK;
      end
   end

   // The two error enables are wired OR across the functions.
   assign anySerrEn   = |{cmdValue[2][`PFCC_BIT_SERR], cmdValue[1][`PFCC_BIT_SERR],
                          cmdValue[0][`PFCC_BIT_SERR]};
   assign anyParityEn = |{cmdValue[2][`PFCC_BIT_PARITY], cmdValue[1][`PFCC_BIT_PARITY],
                          cmdValue[0][`PFCC_BIT_PARITY]};

   // Error outputs: address errors need both enables, data errors need parity.
   always_comb begin
      state_d.serr = addrParityErr && anySerrEn && anyParityEn;
      state_d.perr = dataParityErr && anyParityEn;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign serrAssert = state_q.serr;
   assign perrAssert = state_q.perr;

   // Assertions.
   a_serr_gate: assert property (@(posedge clock) disable iff (!rst_n)
      serrAssert |-> $past(addrParityErr) && $past(anySerrEn) && $past(anyParityEn))
      else $error("System error raised without both enables.");
   a_perr_gate: assert property (@(posedge clock) disable iff (!rst_n)
      $past(dataParityErr) && $past(anyParityEn) |-> perrAssert)
      else $error("Data parity error not signalled.");
   a_perr_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      !$past(anyParityEn) |-> !perrAssert && !serrAssert)
      else $error("Parity error answered while response disabled.");
   a_fixed_zero: assert property (@(posedge clock) disable iff (!rst_n)
      rdData[15:9] == 7'h00 && rdData[7] == 1'b0 && rdData[4:3] == 2'h0)
      else $error("Read-only bits read nonzero.");
   a_write_takes: assert property (@(posedge clock) disable iff (!rst_n)
      cfg.cfgWrite && cmdHit && cfg.func == 2'h0 && cfg.byteEn == 2'h3 |=>
      cmdValue[0] == ($past(cfg.wrData) & `PFCC_WRITE_MASK))
      else $error("Command write not stored.");
   a_func_separate: assert property (@(posedge clock) disable iff (!rst_n)
      cfg.cfgWrite && cfg.func != 2'h1 |=> $stable(cmdValue[1]))
      else $error("Function one changed by another function's write.");
   a_master_gate: assert property (@(posedge clock) disable iff (!rst_n)
      busRequest[0] |-> cmdValue[0][`PFCC_BIT_MASTER])
      else $error("Bus request without initiator enable.");
   a_mem_gate: assert property (@(posedge clock) disable iff (!rst_n)
      memHit[0] && !paletteWrite[0] |-> memClaim[0] == cmdValue[0][`PFCC_BIT_MEM])
      else $error("Memory claim disagrees with enable.");
   a_io_gate: assert property (@(posedge clock) disable iff (!rst_n)
      ioClaim[1] |-> cmdValue[1][`PFCC_BIT_IO])
      else $error("I/O claim without enable.");
   a_no_special: assert property (@(posedge clock) disable iff (!rst_n)
      specialClaim == 3'h0 && writeInvalidateUse == 3'h0)
      else $error("Special cycle or write-invalidate used.");

   // Error paths: each enable on its own, and the OR across functions.
   a_serr_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      !$past(anySerrEn) |-> !serrAssert)
      else $error("System error raised while every driver enable is off.");
   a_serr_raise: assert property (@(posedge clock) disable iff (!rst_n)
      $past(addrParityErr) && $past(anySerrEn) && $past(anyParityEn) |-> serrAssert)
      else $error("Address parity error not reported.");
   a_perr_cause: assert property (@(posedge clock) disable iff (!rst_n)
      perrAssert |-> $past(dataParityErr) && $past(anyParityEn))
      else $error("Data parity error raised without a cause.");
   a_serr_cross: assert property (@(posedge clock) disable iff (!rst_n)
      addrParityErr && cmdValue[2][`PFCC_BIT_SERR] && cmdValue[0][`PFCC_BIT_PARITY] |=>
      serrAssert)
      else $error("Error enables of different functions not combined.");
   a_perr_cross: assert property (@(posedge clock) disable iff (!rst_n)
      dataParityErr && cmdValue[1][`PFCC_BIT_PARITY] |=> perrAssert)
      else $error("Parity enable of one function not honoured.");

   // Read path: the addressed function only, nothing elsewhere.
   a_read_select: assert property (@(posedge clock) disable iff (!rst_n)
      cmdHit && cfg.func == 2'h2 |-> rdData == cmdValue[2])
      else $error("Read returned another function's register.");
   a_read_other: assert property (@(posedge clock) disable iff (!rst_n)
      !cmdHit || cfg.func == 2'h3 |-> rdData == 16'h0000)
      else $error("Read outside the command register returned data.");

   // Reset value and write lanes.
   a_reset_zero: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(rst_n) |-> cmdValue == {3{`PFCC_RESET_VALUE}})
      else $error("Command registers not cleared by reset.");
   a_write_lane: assert property (@(posedge clock) disable iff (!rst_n)
      cfg.cfgWrite && cmdHit && cfg.func == 2'h2 && !cfg.byteEn[1] |=>
      $stable(cmdValue[2][15:8]))
      else $error("Disabled high byte lane was written.");
   a_write_low: assert property (@(posedge clock) disable iff (!rst_n)
      cfg.cfgWrite && cmdHit && cfg.func == 2'h0 && !cfg.byteEn[0] |=>
      $stable(cmdValue[0][7:0]))
      else $error("Disabled low byte lane was written.");
   a_write_ignore: assert property (@(posedge clock) disable iff (!rst_n)
      cfg.cfgWrite && !cmdHit |=> $stable(cmdValue))
      else $error("Write to another offset changed a command register.");

   // Per-function claim, request, ownership and fixed-zero checks.
   generate
      for (genvar f = 0; f < `PFCC_NUM_FUNC; f++) begin : g_chk
         a_mem_claim: assert property (@(posedge clock) disable iff (!rst_n)
            memClaim[f] |-> memHit[f] && ctrl[f].memSpaceEnable && !paletteSnoopCapture[f])
            else $error("Memory cycle claimed while disabled.");
         a_io_claim: assert property (@(posedge clock) disable iff (!rst_n)
            ioClaim[f] |-> ioHit[f] && ctrl[f].ioSpaceEnable && !paletteSnoopCapture[f])
            else $error("I/O cycle claimed while disabled.");
         a_bus_req: assert property (@(posedge clock) disable iff (!rst_n)
            !ctrl[f].bus_initiator_enable |-> !busRequest[f])
            else $error("Bus requested while initiator disabled.");
         a_snoop_take: assert property (@(posedge clock) disable iff (!rst_n)
            paletteSnoopCapture[f] |-> paletteWrite[f] && ctrl[f].paletteSnoop)
            else $error("Palette data snooped while snooping is off.");
         a_ctrl_mirror: assert property (@(posedge clock) disable iff (!rst_n)
            ctrl[f].sys_error_driver_enable == cmdValue[f][`PFCC_BIT_SERR])
            else $error("Driver enable does not follow its register bit.");
         a_func_own: assert property (@(posedge clock) disable iff (!rst_n)
            cfg.cfgWrite && cfg.func != 2'(f) |=> $stable(cmdValue[f]))
            else $error("Register changed by another function's write.");
         a_hard_zero: assert property (@(posedge clock) disable iff (!rst_n)
            (cmdValue[f] & ~`PFCC_WRITE_MASK) == 16'h0000)
            else $error("Read-only command bit holds a one.");
      end
   endgenerate
endmodule
`default_nettype wire

// File: tb/pfcc_host_model.sv
// Host model that presents configuration accesses and bus decode activity.
`timescale 1ns/1ps
`default_nettype none
module pfcc_host_model (
   // Clock.
   input  wire logic              clock,
   // Activity toward the bank.
   output var pfcc_pkg::pfcc_cfg_s cfg,
   output var logic [14:0]        hits,
   output var logic [1:0]         errs
);
   // Drives one cycle of activity just after the rising edge and holds it for the cycle.
   task automatic present(input pfcc_pkg::pfcc_cfg_s c, input logic [14:0] h,
                          input logic [1:0] e);
      @(posedge clock);
      #1;
      cfg  = c;
      hits = h;
      errs = e;
   endtask
   // Starts idle so that no access is seen before the first request.
   initial begin
      cfg  = '0;
      hits = 15'h0000;
      errs = 2'h0;
   end
endmodule
`default_nettype wire

// File: tb/pci_function_command_control_tb.sv
// Self-checking bench for the command register bank.
`timescale 1ns/1ps
`default_nettype none
`define PFCC_CHECK(got, exp) begin nChecks++; if ((got) !== (exp)) begin mismatches++; \
   $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module pci_function_command_control_tb;
   logic                       clock;
   logic                       rst_n;
   pfcc_pkg::pfcc_cfg_s        cfg;
   logic [14:0]                hits;
   logic [1:0]                 errs;
   pfcc_pkg::pfcc_word_t       rdData;
   pfcc_pkg::pfcc_ctrl_s [2:0] ctrl;
   logic [2:0]                 memClaim, ioClaim, snoop, special, busReq, wiUse;
   logic                       serrAssert, perrAssert;
   logic [17:0]                claims;
   int                         mismatches, nChecks;
   pfcc_pkg::pfcc_word_t       shadow [3];
   logic [1:0]                 expErr;
   logic [53:0]                notes [$];

   assign claims = {memClaim, ioClaim, snoop, special, busReq, wiUse};
   // Free-running 10 MHz clock.
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   pfcc_host_model host (.clock(clock), .cfg(cfg), .hits(hits), .errs(errs));
   pfcc_command_bank dut (.clock(clock), .rst_n(rst_n), .cfg(cfg), .rdData(rdData),
      .memHit(hits[14:12]), .ioHit(hits[11:9]), .paletteWrite(hits[8:6]),
      .specialCycle(hits[5:3]), .masterWant(hits[2:0]), .addrParityErr(errs[1]),
      .dataParityErr(errs[0]), .ctrl(ctrl), .memClaim(memClaim), .ioClaim(ioClaim),
      .paletteSnoopCapture(snoop), .specialClaim(special), .busRequest(busReq),
      .writeInvalidateUse(wiUse), .serrAssert(serrAssert), .perrAssert(perrAssert));

   // Prints the verdict and ends the run.
   task automatic results();
      if (mismatches == 0 && nChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Works out every output of the cycle from the shadow registers.
   function automatic logic [53:0] expect_of(input pfcc_pkg::pfcc_cfg_s c, input logic [14:0] h);
      logic [17:0] ct;
      logic [2:0]  m, i, p, b;
      logic [15:0] rd;
      for (int f = 0; f < 3; f++) begin
         ct[f*6 +: 6] = {shadow[f][0], shadow[f][1], shadow[f][2], shadow[f][5],
                         shadow[f][6], shadow[f][8]};
         p[f] = h[6+f] & shadow[f][5];
         m[f] = h[12+f] & shadow[f][1] & ~p[f];
         i[f] = h[9+f] & shadow[f][0] & ~p[f];
         b[f] = h[f] & shadow[f][2];
      end
      rd = (c.offset == 8'h04 && c.func != 2'h3) ? shadow[c.func] : 16'h0000;
      return {rd, ct, m, i, p, 3'h0, b, 3'h0, expErr};
   endfunction

   // Random traffic in two reset periods, noting each cycle's expected outputs.
   initial begin
      pfcc_pkg::pfcc_cfg_s c;
      logic [14:0]         h;
      logic [1:0]          e;
      logic [15:0]         m;
      logic                orS, orP;
      rst_n = 1'b0;
      mismatches = 0;
      nChecks = 0;
      void'($urandom(32'hF511C529));
      for (int ph = 0; ph < 2; ph++) begin
         rst_n = 1'b0;
         repeat (12) @(posedge clock);
         #1;
         rst_n = 1'b1;
         foreach (shadow[f]) shadow[f] = 16'h0000;
         expErr = 2'h0;
         for (int n = 0; n < 400; n++) begin
            {c, h, e} = 46'({$urandom, $urandom});
            if (c.offset[1:0] != 2'h3) c.offset = 8'h04;
            host.present(c, h, e);
            notes.push_back(expect_of(c, h));
            orS = shadow[0][8] | shadow[1][8] | shadow[2][8];
            orP = shadow[0][6] | shadow[1][6] | shadow[2][6];
            expErr = {e[1] & orS & orP, e[0] & orP};
            if (c.cfgWrite && c.offset == 8'h04 && c.func != 2'h3) begin
               m = 16'h0167 & {{8{c.byteEn[1]}}, {8{c.byteEn[0]}}};
               shadow[c.func] = (shadow[c.func] & ~m) | (c.wrData & m);
            end
         end
         // Idle cycle: checks the last error cycle and leaves no stale write for reset.
         host.present('0, 15'h0000, 2'h0);
         notes.push_back(expect_of('0, 15'h0000));
         @(posedge clock);
         #1;
      end
      results();
   end

   // Compares the oldest note with the settled outputs in mid-cycle.
   always @(negedge clock) begin
      logic [53:0] n;
      if (notes.size() > 0) begin
         n = notes.pop_front();
         `PFCC_CHECK(rdData, n[53:38])
         `PFCC_CHECK(ctrl, n[37:20])
         `PFCC_CHECK(claims, n[19:2])
         `PFCC_CHECK({serrAssert, perrAssert}, n[1:0])
      end
   end

   // Cuts a hang short well after the expected run length.
   initial begin
      #200000;
      mismatches++;
      $display("[FAIL] %0t run did not finish", $time);
      results();
   end
endmodule
`default_nettype wire
